// ==== hw/wkm_regs.vh ====
// Register offsets, field positions and reset values of the wake frame match configuration
`ifndef WKM_REGS_VH
`define WKM_REGS_VH

// ****************************************
// Register offsets (7-bit control interface address)
// ****************************************
`define WKM_ADDR_W             7
`define WKM_OFS_ID_MASK_LOW    7'h35
`define WKM_OFS_LENGTH_CODE    7'h36
`define WKM_OFS_PAYLOAD_7_6    7'h37
`define WKM_OFS_PAYLOAD_5_4    7'h38
`define WKM_OFS_PAYLOAD_3_2    7'h39
`define WKM_OFS_PAYLOAD_1_0    7'h3a

// ****************************************
// Field layout
// ****************************************
`define WKM_DATA_W             16
`define WKM_MASK_RW_BITS       16'hff7c
`define WKM_DLC_RW_BITS        16'h000f
`define WKM_DLC_MSB            3
`define WKM_MASK_SEL_BIT1      3
`define WKM_MASK_SEL_BIT0      2
`define WKM_ID_LOW_W           13
`define WKM_BYTE_HI_MSB        15
`define WKM_BYTE_HI_LSB        8
`define WKM_BYTE_LO_MSB        7
`define WKM_BYTE_LO_LSB        0
`define WKM_FULL_PAYLOAD_BYTES 4'h8

// ****************************************
// Reset values
// ****************************************
`define WKM_RST_VALUE          16'h0000
`define WKM_ALL_WRITTEN        6'h3f

`endif

// ==== hw/wkm_id_cmp.v ====
// Masked comparison of the low identifier bits of a received wake-up frame
`timescale 1ns/1ps
`default_nettype none
`include "wkm_regs.vh"

module wkm_id_cmp
(
  input  wire [`WKM_DATA_W-1:0]   mask_reg,
  input  wire [`WKM_ID_LOW_W-1:0] rx_id,
  input  wire [`WKM_ID_LOW_W-1:0] exp_id,
  output wire                     id_ok
);

  // ****************************************
  // Mask bit to identifier bit mapping
  // ****************************************
  // Register bit 7 is reserved, so id bits 4..0 sit at 6..2 and 12..5 at 15..8
  wire [`WKM_ID_LOW_W-1:0] sel;
  assign sel = {mask_reg[15:8], mask_reg[6:4],
                mask_reg[`WKM_MASK_SEL_BIT1], mask_reg[`WKM_MASK_SEL_BIT0]}; // (R1)

  // Zero leaves the bit out, one demands equality
  assign id_ok = ~|((rx_id ^ exp_id) & sel); // (R1)

endmodule
`default_nettype wire

// ==== hw/wkm_payload_cmp.v ====
// Byte-wise payload comparison limited to the length the received code announces
`timescale 1ns/1ps
`default_nettype none
`include "wkm_regs.vh"

module wkm_payload_cmp
(
  input  wire [3:0]  rx_dlc,
  input  wire [63:0] exp_payload,
  input  wire [63:0] rx_payload,
  output reg         data_ok
);

  // Codes 8..15 all stand for a full eight-byte payload
  function [3:0] dlc_to_bytes;
    input [3:0] code;
    begin
      if (code[`WKM_DLC_MSB])
        dlc_to_bytes = `WKM_FULL_PAYLOAD_BYTES; // (R3)
      else
        dlc_to_bytes = code; // (R3)
    end
  endfunction

  // ****************************************
  // Compare from byte zero up to the length
  // ****************************************
  reg [3:0] nbytes;
  integer   i;

  always @*
  begin
    nbytes  = dlc_to_bytes(rx_dlc);
    data_ok = 1'b1;
    for (i = 0; i < 8; i = i + 1)
    begin
      if (i < nbytes && exp_payload[i*8 +: 8] != rx_payload[i*8 +: 8])
        data_ok = 1'b0; // (R10)
    end
  end

endmodule
`default_nettype wire

// ==== hw/wkm_cfg.v ====
// Wake frame match configuration registers and low-identifier, length and payload matcher
//
// Notes on behaviour
// (R1) Each of the two lowest identifier mask bits decides whether that identifier bit is compared (one) or ignored (zero).
// (R2) Mask register bits 1:0 and length-code register bits 15:4 always read zero whatever is written.
// (R3) The length code is a 4-bit read-write field, codes 0..7 mean that many bytes and 8..15 mean eight bytes.
// (R4) A frame only qualifies when its length code equals the configured code in all four bits.
// (R5) A length code of zero stands for a zero-byte payload or the cleared field.
// (R6) Each payload register holds the higher-numbered byte in 15:8 and the lower one in 7:0, bit 0 least significant.
// (R7) Payload registers sit at four consecutive addresses, bytes 7/6 lowest and bytes 1/0 highest, after the length code.
// (R8) Power-on or soft reset clears every bit of the mask, length-code and payload registers.
// (R9) A restart leaves configurable bits undefined with reserved bits zero, so software must rewrite before relying on matching.
// (R10) The matcher compares received payload bytes against expected ones in order from byte zero up to the length.
`timescale 1ns/1ps
`default_nettype none
`include "wkm_regs.vh"

module wkm_cfg
(
  input  wire                      REF_CLK,
  input  wire                      RESET_N,
  input  wire                      SOFT_RESET,
  input  wire                      RESTART,
  input  wire                      REG_WR_EN,
  input  wire                      REG_RD_EN,
  input  wire [`WKM_ADDR_W-1:0]    REG_ADDR,
  input  wire [`WKM_DATA_W-1:0]    REG_WDATA,
  output reg  [`WKM_DATA_W-1:0]    REG_RDATA,
  output reg                       REG_RD_VALID,
  input  wire                      RX_FRAME_VALID,
  input  wire [`WKM_ID_LOW_W-1:0]  RX_ID_LOW,
  input  wire [`WKM_ID_LOW_W-1:0]  EXP_ID_LOW,
  input  wire [3:0]                RX_DLC,
  input  wire [63:0]               RX_PAYLOAD,
  output reg                       WAKE_MATCH,
  output reg                       WAKE_MISMATCH,
  output reg                       CFG_STALE
);

  // ****************************************
  // Configuration storage
  // ****************************************
  reg  [`WKM_DATA_W-1:0] id_mask_low_ff;
  reg  [3:0]             length_code_ff;
  reg  [`WKM_DATA_W-1:0] payload_7_6_ff;
  reg  [`WKM_DATA_W-1:0] payload_5_4_ff;
  reg  [`WKM_DATA_W-1:0] payload_3_2_ff;
  reg  [`WKM_DATA_W-1:0] payload_1_0_ff;

  reg  [`WKM_DATA_W-1:0] nxt_id_mask_low;
  reg  [3:0]             nxt_length_code;
  reg  [`WKM_DATA_W-1:0] nxt_payload_7_6;
  reg  [`WKM_DATA_W-1:0] nxt_payload_5_4;
  reg  [`WKM_DATA_W-1:0] nxt_payload_3_2;
  reg  [`WKM_DATA_W-1:0] nxt_payload_1_0;

  // Tracks which registers were rewritten since the last restart
  reg  [5:0]             written_ff;
  reg  [5:0]             nxt_written;
  reg                    nxt_stale;

  reg  [`WKM_DATA_W-1:0] nxt_rdata;
  reg                    nxt_rd_valid;
  reg                    nxt_match;
  reg                    nxt_mismatch;

  wire                   id_ok;
  wire                   data_ok;
  wire                   dlc_ok;
  wire [63:0]            exp_payload;
  wire                   frame_ok;

  // Per-register write strobes, one-hot from the decoder
  wire                   wr_mask_low;
  wire                   wr_length_code;
  wire                   wr_payload_7_6;
  wire                   wr_payload_5_4;
  wire                   wr_payload_3_2;
  wire                   wr_payload_1_0;

  // ****************************************
  // Address decode
  // ****************************************
  function [5:0] reg_select;
    input [`WKM_ADDR_W-1:0] addr;
    begin
      case (addr)
        `WKM_OFS_ID_MASK_LOW: reg_select = 6'h01;
        `WKM_OFS_LENGTH_CODE: reg_select = 6'h02;
        `WKM_OFS_PAYLOAD_7_6: reg_select = 6'h04; // (R7)
        `WKM_OFS_PAYLOAD_5_4: reg_select = 6'h08; // (R7)
        `WKM_OFS_PAYLOAD_3_2: reg_select = 6'h10; // (R7)
        `WKM_OFS_PAYLOAD_1_0: reg_select = 6'h20; // (R7)
        default:              reg_select = 6'h00;
      endcase
    end
  endfunction

  wire [5:0] wr_sel;
  wire [5:0] rd_sel;
  assign wr_sel = REG_WR_EN ? reg_select(REG_ADDR) : 6'h00;
  assign rd_sel = reg_select(REG_ADDR);

  assign wr_mask_low    = wr_sel[0];
  assign wr_length_code = wr_sel[1];
  assign wr_payload_7_6 = wr_sel[2];
  assign wr_payload_5_4 = wr_sel[3];
  assign wr_payload_3_2 = wr_sel[4];
  assign wr_payload_1_0 = wr_sel[5];

  // ****************************************
  // Field helpers
  // ****************************************
  // Used on the write and the read path, so a reserved bit never leaks out
  function [`WKM_DATA_W-1:0] keep_rw_bits;
    input [`WKM_DATA_W-1:0] value;
    input [`WKM_DATA_W-1:0] rw_bits;
    begin
      keep_rw_bits = value & rw_bits; // (R2)
    end
  endfunction

  // ****************************************
  // Register writes
  // ****************************************
  always @*
  begin
    nxt_id_mask_low = id_mask_low_ff;
    nxt_length_code = length_code_ff;
    nxt_payload_7_6 = payload_7_6_ff;
    nxt_payload_5_4 = payload_5_4_ff;
    nxt_payload_3_2 = payload_3_2_ff;
    nxt_payload_1_0 = payload_1_0_ff;
    if (wr_mask_low)
      nxt_id_mask_low = keep_rw_bits(REG_WDATA, `WKM_MASK_RW_BITS); // (R2)
    if (wr_length_code)
      nxt_length_code = REG_WDATA[`WKM_DLC_MSB:0]; // (R3)
    if (wr_payload_7_6)
      nxt_payload_7_6 = REG_WDATA; // (R6)
    if (wr_payload_5_4)
      nxt_payload_5_4 = REG_WDATA; // (R6)
    if (wr_payload_3_2)
      nxt_payload_3_2 = REG_WDATA; // (R6)
    if (wr_payload_1_0)
      nxt_payload_1_0 = REG_WDATA; // (R6)
    // Applied last so it beats a write in the same cycle
    if (SOFT_RESET)
    begin
      nxt_id_mask_low = `WKM_RST_VALUE; // (R8)
      nxt_length_code = 4'h0; // (R8)
      nxt_payload_7_6 = `WKM_RST_VALUE; // (R8)
      nxt_payload_5_4 = `WKM_RST_VALUE; // (R8)
      nxt_payload_3_2 = `WKM_RST_VALUE; // (R8)
      nxt_payload_1_0 = `WKM_RST_VALUE; // (R8)
    end
  end

  always @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      id_mask_low_ff <= `WKM_RST_VALUE; // (R8)
      length_code_ff <= 4'h0; // (R8)
      payload_7_6_ff <= `WKM_RST_VALUE; // (R8)
      payload_5_4_ff <= `WKM_RST_VALUE; // (R8)
      payload_3_2_ff <= `WKM_RST_VALUE; // (R8)
      payload_1_0_ff <= `WKM_RST_VALUE; // (R8)
    end
    else
    begin
      // A restart does not touch the contents: they keep whatever they held
      id_mask_low_ff <= nxt_id_mask_low;
      length_code_ff <= nxt_length_code;
      payload_7_6_ff <= nxt_payload_7_6;
      payload_5_4_ff <= nxt_payload_5_4;
      payload_3_2_ff <= nxt_payload_3_2;
      payload_1_0_ff <= nxt_payload_1_0;
    end
  end

  // ****************************************
  // Stale configuration tracking
  // ****************************************
  // Restart wins over a write in the same cycle, so no stale content slips through
  always @*
  begin
    nxt_written = written_ff | wr_sel;
    nxt_stale   = CFG_STALE;
    if (nxt_written == `WKM_ALL_WRITTEN)
      nxt_stale = 1'b0; // (R9)
    if (SOFT_RESET)
      nxt_stale = 1'b0;
    if (RESTART)
    begin
      nxt_written = 6'h00; // (R9)
      nxt_stale   = 1'b1; // (R9)
    end
  end

  always @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      written_ff <= 6'h00;
      CFG_STALE  <= 1'b0;
    end
    else
    begin
      written_ff <= nxt_written;
      CFG_STALE  <= nxt_stale;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Read data is taken before the edge, so a read beside a write returns the old value
  always @*
  begin
    nxt_rd_valid = REG_RD_EN;
    nxt_rdata    = `WKM_RST_VALUE;
    case (rd_sel)
      6'h01:   nxt_rdata = keep_rw_bits(id_mask_low_ff, `WKM_MASK_RW_BITS); // (R2)
      6'h02:   nxt_rdata = keep_rw_bits({12'h000, length_code_ff}, `WKM_DLC_RW_BITS); // (R2)
      6'h04:   nxt_rdata = payload_7_6_ff;
      6'h08:   nxt_rdata = payload_5_4_ff;
      6'h10:   nxt_rdata = payload_3_2_ff;
      6'h20:   nxt_rdata = payload_1_0_ff;
      default: nxt_rdata = `WKM_RST_VALUE;
    endcase
  end

  always @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      REG_RDATA    <= `WKM_RST_VALUE;
      REG_RD_VALID <= 1'b0;
    end
    else
    begin
      REG_RD_VALID <= nxt_rd_valid;
      if (REG_RD_EN)
        REG_RDATA <= nxt_rdata;
    end
  end

  // ****************************************
  // Frame matching
  // ****************************************
  // Byte n of the expected payload lands at bits 8n+7..8n
  assign exp_payload = {payload_7_6_ff, payload_5_4_ff, payload_3_2_ff, payload_1_0_ff}; // (R6)

  // Exact four-bit equality: 9 against a configured 8 is a miss
  assign dlc_ok = (RX_DLC == length_code_ff); // (R4)

  wkm_id_cmp wkm_id_cmp_i
  (
    .mask_reg (id_mask_low_ff),
    .rx_id    (RX_ID_LOW),
    .exp_id   (EXP_ID_LOW),
    .id_ok    (id_ok)
  );

  // A zero code compares no bytes, so it matches on identifier alone
  wkm_payload_cmp wkm_payload_cmp_i
  (
    .rx_dlc      (RX_DLC),
    .exp_payload (exp_payload),
    .rx_payload  (RX_PAYLOAD),
    .data_ok     (data_ok)
  );

  // Every frame gets exactly one verdict, taken from the same term
  assign frame_ok = id_ok & dlc_ok & data_ok; // (R4) (R5) (R10)

  always @*
  begin
    nxt_match    = 1'b0;
    nxt_mismatch = 1'b0;
    if (RX_FRAME_VALID)
    begin
      nxt_match    = frame_ok; // (R4)
      nxt_mismatch = ~frame_ok;
    end
  end

  always @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      WAKE_MATCH    <= 1'b0;
      WAKE_MISMATCH <= 1'b0;
    end
    else
    begin
      WAKE_MATCH    <= nxt_match;
      WAKE_MISMATCH <= nxt_mismatch;
    end
  end

endmodule
`default_nettype wire

// ==== dv/wkm_cfg_properties.sv ====
// Port-level assertions for the wake frame match configuration
`timescale 1ns/1ps
`default_nettype none
module wkm_cfg_props
(
  input wire logic        REF_CLK,
  input wire logic        RESET_N,
  input wire logic        SOFT_RESET,
  input wire logic        RESTART,
  input wire logic        REG_WR_EN,
  input wire logic        REG_RD_EN,
  input wire logic [6:0]  REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA,
  input wire logic        RX_FRAME_VALID,
  input wire logic [3:0]  RX_DLC,
  input wire logic        WAKE_MATCH,
  input wire logic        WAKE_MISMATCH,
  input wire logic        CFG_STALE
);
  // ****
  // Shadow of the configured length code
  // ****
  logic [3:0] dlc_ff;
  // Soft reset beats a write in the same cycle
  always_ff @(posedge REF_CLK or negedge RESET_N)
    if (!RESET_N)
      dlc_ff <= 4'h0;
    else if (SOFT_RESET)
      dlc_ff <= 4'h0;
    else if (REG_WR_EN && REG_ADDR == 7'h36)
      dlc_ff <= REG_WDATA[3:0];
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);
  mask_resv_a: assert property (REG_RD_EN && REG_ADDR == 7'h35 |=> REG_RDATA[1:0] == 2'h0)
    else $error("mask reserved bits set");
  dlc_resv_a: assert property (REG_RD_EN && REG_ADDR == 7'h36 |=> REG_RDATA[15:4] == 12'h000)
    else $error("length reserved bits set");
  one_verdict_a: assert property (RX_FRAME_VALID |=> WAKE_MATCH != WAKE_MISMATCH)
    else $error("frame verdict not unique");
  no_verdict_a: assert property (!RX_FRAME_VALID |=> !(WAKE_MATCH || WAKE_MISMATCH))
    else $error("verdict without frame");
  dlc_exact_a: assert property (RX_FRAME_VALID && RX_DLC != dlc_ff |=> !WAKE_MATCH)
    else $error("match with other length code");
  soft_clear_a: assert property (SOFT_RESET ##1 REG_RD_EN |=> REG_RDATA == 16'h0000)
    else $error("register not cleared");
  stale_set_a: assert property (RESTART && !SOFT_RESET |=> CFG_STALE)
    else $error("stale flag not set");
  stale_keep_a: assert property (CFG_STALE && !REG_WR_EN && !SOFT_RESET |=> CFG_STALE)
    else $error("stale flag dropped");
endmodule
bind wkm_cfg wkm_cfg_props wkm_cfg_props_i (.REF_CLK, .RESET_N, .SOFT_RESET, .RESTART, .REG_WR_EN,
  .REG_RD_EN, .REG_ADDR, .REG_WDATA, .REG_RDATA, .RX_FRAME_VALID, .RX_DLC, .WAKE_MATCH,
  .WAKE_MISMATCH, .CFG_STALE);
`default_nettype wire

// ==== dv/wkm_can_node.sv ====
// Bus node model that hands received wake-up frames to the matcher
`timescale 1ns/1ps
`default_nettype none
module wkm_can_node
(
  input  wire logic        clk,
  output var  logic        vld,
  output var  logic [12:0] id,
  output var  logic [3:0]  dlc,
  output var  logic [63:0] pay
);
  initial
  begin
    vld = 1'b0;
    id = 13'h0000;
    dlc = 4'h0;
    pay = 64'h0000_0000_0000_0000;
  end
  // ****
  // One frame, valid for one cycle
  // ****
  task automatic send(input logic [12:0] i, input logic [3:0] d, input logic [63:0] p);
    @(posedge clk);
    #1;
    vld = 1'b1;
    id = i;
    dlc = d;
    pay = p;
    @(posedge clk);
    #1;
    vld = 1'b0;
    // Stale fields inverted so nothing leans on leftovers
    id = ~i;
    dlc = ~d;
    pay = ~p;
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the wake frame match configuration
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        REF_CLK, RESET_N, SOFT_RESET, RESTART, REG_WR_EN, REG_RD_EN;
  logic [6:0]  REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA;
  logic        REG_RD_VALID, RX_FRAME_VALID, WAKE_MATCH, WAKE_MISMATCH, CFG_STALE;
  logic [12:0] RX_ID_LOW, EXP_ID_LOW;
  logic [3:0]  RX_DLC;
  logic [63:0] RX_PAYLOAD;
  int          bad_count = 0;
  int          n_checks = 0;
  wkm_cfg wkm_cfg_i (.REF_CLK, .RESET_N, .SOFT_RESET, .RESTART, .REG_WR_EN, .REG_RD_EN, .REG_ADDR,
    .REG_WDATA, .REG_RDATA, .REG_RD_VALID, .RX_FRAME_VALID, .RX_ID_LOW, .EXP_ID_LOW, .RX_DLC,
    .RX_PAYLOAD, .WAKE_MATCH, .WAKE_MISMATCH, .CFG_STALE);
  wkm_can_node wkm_can_node_i (.clk(REF_CLK), .vld(RX_FRAME_VALID), .id(RX_ID_LOW), .dlc(RX_DLC),
    .pay(RX_PAYLOAD));
  // ****
  // Shared tasks
  // ****
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask
  task automatic tick();
    @(posedge REF_CLK);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    tick();
    REG_WR_EN = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    tick();
    REG_WR_EN = 1'b0;
    REG_WDATA = ~d;
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    tick();
    REG_RD_EN = 1'b1;
    REG_ADDR = a;
    tick();
    REG_RD_EN = 1'b0;
    check("rd_valid", {15'h0000, REG_RD_VALID}, 16'h0001);
    check("rdata", REG_RDATA, e);
  endtask
  task automatic frame(input logic [12:0] i, input logic [3:0] d, input logic [63:0] p, input logic m);
    wkm_can_node_i.send(i, d, p);
    check("match", {15'h0000, WAKE_MATCH}, {15'h0000, m});
    check("mismatch", {15'h0000, WAKE_MISMATCH}, {15'h0000, !m});
  endtask
  function automatic logic [15:0] pat(input int i, input int k);
    return 16'h1357 * 16'(i + 3) ^ {16{k[0]}};
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    logic [15:0] m [6];
    m = '{16'hff7c, 16'h000f, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
    for (int i = 0; i < 6; i++)
      rd(7'h35 + 7'(i), 16'h0000);
    for (int k = 0; k < 2; k++)
    begin
      for (int i = 0; i < 6; i++)
        wr(7'h35 + 7'(i), pat(i, k));
      for (int i = 0; i < 6; i++)
        rd(7'h35 + 7'(i), pat(i, k) & m[i]);
    end
    wr(7'h3b, 16'hffff);
    rd(7'h3b, 16'h0000);
    $display("regs done");
  endtask
  task automatic t_match();
    EXP_ID_LOW = 13'h0002;
    wr(7'h35, 16'h000c);
    wr(7'h36, 16'h0003);
    wr(7'h3a, 16'h2211);
    wr(7'h39, 16'h4433);
    wr(7'h38, 16'h6655);
    wr(7'h37, 16'h8877);
    frame(13'h1ff6, 4'h3, 64'hffff_ffff_ff33_2211, 1'b1);
    frame(13'h0003, 4'h3, 64'h0000_0000_0033_2211, 1'b0);
    frame(13'h0002, 4'h3, 64'h0000_0000_0034_2211, 1'b0);
    frame(13'h0002, 4'h4, 64'h0000_0000_4433_2211, 1'b0);
    wr(7'h35, 16'h0008);
    frame(13'h0003, 4'h3, 64'h0000_0000_0033_2211, 1'b1);
    wr(7'h35, 16'h0004);
    frame(13'h0003, 4'h3, 64'h0000_0000_0033_2211, 1'b0);
    wr(7'h36, 16'h0008);
    frame(13'h0002, 4'h9, 64'h8877_6655_4433_2211, 1'b0);
    frame(13'h0002, 4'h8, 64'h8877_6655_4433_2211, 1'b1);
    wr(7'h36, 16'h000f);
    frame(13'h0002, 4'hf, 64'h0077_6655_4433_2211, 1'b0);
    wr(7'h36, 16'h0000);
    frame(13'h0002, 4'h0, 64'hffff_ffff_ffff_ffff, 1'b1);
    $display("match done");
  endtask
  task automatic t_restart();
    tick();
    RESTART = 1'b1;
    tick();
    RESTART = 1'b0;
    check("stale", {15'h0000, CFG_STALE}, 16'h0001);
    for (int i = 0; i < 5; i++)
      wr(7'h35 + 7'(i), 16'h0000);
    tick();
    check("stale", {15'h0000, CFG_STALE}, 16'h0001);
    wr(7'h3a, 16'h0000);
    tick();
    check("stale", {15'h0000, CFG_STALE}, 16'h0000);
    $display("restart done");
  endtask
  task automatic t_soft();
    wr(7'h38, 16'h5a5a);
    tick();
    RESTART = 1'b1;
    tick();
    RESTART = 1'b0;
    SOFT_RESET = 1'b1;
    REG_WR_EN = 1'b1;
    REG_ADDR = 7'h37;
    REG_WDATA = 16'hffff;
    tick();
    SOFT_RESET = 1'b0;
    REG_WR_EN = 1'b0;
    REG_RD_EN = 1'b1;
    REG_ADDR = 7'h38;
    check("stale", {15'h0000, CFG_STALE}, 16'h0000);
    tick();
    REG_RD_EN = 1'b0;
    check("rdata", REG_RDATA, 16'h0000);
    for (int i = 0; i < 6; i++)
      rd(7'h35 + 7'(i), 16'h0000);
    // Asynchronous reset in mid-run must clear as well
    wr(7'h3a, 16'h1234);
    RESET_N = 1'b0;
    tick();
    RESET_N = 1'b1;
    rd(7'h3a, 16'h0000);
    $display("soft done");
  endtask
  initial
  begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end
  initial
  begin
    {RESET_N, SOFT_RESET, RESTART, REG_WR_EN, REG_RD_EN} = 5'h00;
    REG_ADDR = 7'h00;
    REG_WDATA = 16'h0000;
    EXP_ID_LOW = 13'h0000;
    repeat (2) @(posedge REF_CLK);
    #1;
    RESET_N = 1'b1;
    t_regs();
    t_match();
    t_restart();
    t_soft();
    close_out();
  end
  // Hang guard
  initial
  begin
    #100000;
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
